// file: shared/acs_pkg.sv
// acs_pkg: register map, field layout, reset values and carrier structs
// of the cipher dma control and status block.
// assumes a byte-addressed register port with one aligned word per register.

package acs_pkg;

    // ------------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------------
    localparam int ACS_ADDR_W = 8;
    localparam int ACS_DATA_W = 32;
    localparam int ACS_KEY_WORDS = 4;
    localparam int ACS_KEY_W = 128;
    localparam int ACS_FLAG_W = 6;
    localparam int ACS_SRC_W = 3;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ACS_OFS_START = 8'h4c;
    localparam logic [7:0] ACS_OFS_STATUS = 8'h50;
    localparam logic [7:0] ACS_OFS_KEY0 = 8'h54;
    localparam logic [7:0] ACS_OFS_KEY3 = 8'h60;
    localparam logic [7:0] ACS_OFS_IRQ_EN = 8'h64;
    localparam logic [7:0] ACS_OFS_IRQ_STAT = 8'h68;
    localparam logic [7:0] ACS_OFS_IRQ_CLR = 8'h6c;
    localparam logic [7:0] ACS_OFS_SRC_SEL = 8'h70;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ACS_BIT_START = 0;
    localparam int ACS_BIT_DONE = 0;
    localparam int ACS_BIT_TAG_FAIL = 1;
    localparam int ACS_BIT_OVERFLOW = 2;
    localparam int ACS_BIT_CONFLICT = 3;
    localparam int ACS_BIT_EMPTY = 4;
    localparam int ACS_BIT_FULL = 5;

    // ------------------------------------------------------------------
    // reset values and source port codes
    // ------------------------------------------------------------------
    localparam logic [5:0] ACS_STATUS_RST = 6'h10;
    localparam logic [5:0] ACS_IRQ_RST = 6'h00;
    localparam logic [2:0] ACS_SRC_SCRATCH = 3'h0;
    localparam logic [2:0] ACS_SRC_RX0 = 3'h1;
    localparam logic [2:0] ACS_SRC_RX1 = 3'h2;
    localparam logic [2:0] ACS_SRC_TX = 3'h3;

    // ------------------------------------------------------------------
    // carrier structs
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_req_s;

    typedef struct packed {
        logic started;
        logic done;
        logic tag_fail;
        logic overflow;
        logic conflict;
        logic ram_empty;
        logic ram_full;
    } acs_engine_ev_s;

    typedef struct packed {
        logic scratch;
        logic rx0;
        logic rx1;
        logic tx;
        logic unused;
    } acs_src_sel_s;

    typedef struct packed {
        logic start;
        logic [3:0][31:0] key;
        logic [5:0] irq_en;
        logic [2:0] src_code;
        logic ram_empty_d;
        logic ram_full_d;
        logic [31:0] rdata;
    } acs_state_s;

endpackage

// file: verif/acs_properties.sv
// acs_properties: concurrent checks on the ports of acs_control_status.
// assumes one clock, clk_sys, and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module acs_chk #(
    parameter int KEY_WORDS = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire acs_pkg::acs_bus_req_s bus_req,
    input wire logic [31:0] bus_rdata,
    // cipher engine
    input wire acs_pkg::acs_engine_ev_s engine_ev,
    input wire logic start_req,
    input wire logic [127:0] cipher_key,
    input wire acs_pkg::acs_src_sel_s source_port_select,
    // status view and interrupt
    input wire logic [5:0] cipher_status_reg,
    input wire logic irq
);
    import acs_pkg::*;
    logic wr_start;
    logic wr_stat;
    logic [5:0] clr_mask;
    logic [5:0] keep_r;

    assign wr_start = bus_req.wr && bus_req.addr == ACS_OFS_START
        && bus_req.wdata[0];
    assign wr_stat = bus_req.wr && bus_req.addr == ACS_OFS_STATUS;
    assign clr_mask = wr_stat ? bus_req.wdata[5:0] : 6'h00;

    // flags that were set and not cleared by a one must survive the edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            keep_r <= 6'h00;
        end else begin
            keep_r <= cipher_status_reg & ~clr_mask;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    chk_start_set: assert property (wr_start |=> start_req)
        else $error("start bit not set by write");
    chk_start_clear: assert property (
        start_req && engine_ev.started && !wr_start |=> !start_req)
        else $error("start bit not cleared when engine began");
    chk_done_flag: assert property (engine_ev.done |=> cipher_status_reg[0])
        else $error("done flag not set");
    chk_tag_flag: assert property (
        engine_ev.tag_fail |=> cipher_status_reg[1])
        else $error("tag failure flag not set");
    chk_ovf_flag: assert property (
        engine_ev.overflow |=> cipher_status_reg[2])
        else $error("overflow flag not set");
    chk_conf_flag: assert property (
        engine_ev.conflict |=> cipher_status_reg[3])
        else $error("contention flag not set");
    chk_empty_flag: assert property (
        engine_ev.ram_empty |=> cipher_status_reg[4])
        else $error("empty flag not set");
    chk_full_flag: assert property (
        engine_ev.ram_full |=> cipher_status_reg[5])
        else $error("full flag not set");
    chk_flag_sticky: assert property (
        (cipher_status_reg & keep_r) == keep_r)
        else $error("status flag dropped without a clearing one");
    chk_done_w1c: assert property (
        clr_mask[0] && !engine_ev.done |=> !cipher_status_reg[0])
        else $error("done flag not cleared by writing one");
    chk_key_word: assert property (
        bus_req.wr && bus_req.addr == ACS_OFS_KEY0
        |=> cipher_key[31:0] == $past(bus_req.wdata))
        else $error("key word 0 not loaded");

    cov_start: cover property (start_req ##1 !start_req);
    cov_clear: cover property (wr_stat && bus_req.wdata[0]);
    cov_irq: cover property (!irq ##1 irq);
endmodule

bind acs_control_status acs_chk #(.KEY_WORDS(KEY_WORDS)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .engine_ev(engine_ev), .start_req(start_req),
    .cipher_key(cipher_key), .source_port_select(source_port_select),
    .cipher_status_reg(cipher_status_reg), .irq(irq));
`default_nettype wire

// file: verif/testbench.sv
// testbench: register-port tests of acs_control_status.
// assumes the design answers reads one cycle after the read strobe.
// payload length lies outside this block, so no stimulus programs it
// and its exclusion of tag and check lengths stays with software
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import acs_pkg::*;
    logic clk_sys;
    logic reset;
    acs_bus_req_s bus_req;
    acs_engine_ev_s engine_ev;
    logic [31:0] bus_rdata;
    logic start_req;
    logic [127:0] cipher_key;
    acs_src_sel_s source_port_select;
    logic [5:0] cipher_status_reg;
    logic irq;
    int error_cnt;
    int checked;

    acs_control_status #(.KEY_WORDS(4)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .engine_ev(engine_ev),
        .start_req(start_req), .cipher_key(cipher_key),
        .source_port_select(source_port_select),
        .cipher_status_reg(cipher_status_reg), .irq(irq));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req.wr <= 1'b1;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        check("read data", bus_rdata, exp);
    endtask

    task automatic pulse(input logic [6:0] v);
        @(posedge clk_sys);
        engine_ev <= acs_engine_ev_s'(v);
        @(posedge clk_sys);
        engine_ev <= '0;
        #1;
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        bus_req = '0;
        engine_ev = '0;
        error_cnt = 0;
        checked = 0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        rd(ACS_OFS_STATUS, 32'h0000_0010);
        rd(ACS_OFS_START, 32'h0000_0000);
        check("source select", source_port_select, 5'h10);
        $display("reset values done");
        wr(ACS_OFS_START, 32'h0000_0001);
        check("start set", start_req, 1'b1);
        wr(ACS_OFS_START, 32'h0000_0000);
        check("start held", start_req, 1'b1);
        pulse(7'h40);
        check("start cleared", start_req, 1'b0);
        rd(ACS_OFS_START, 32'h0000_0000);
        $display("start bit done");
        wr(ACS_OFS_STATUS, 32'h0000_003f);
        check("status clear", cipher_status_reg, 6'h00);
        for (int i = 0; i < 6; i++) begin
            pulse(7'h01 << (5 - i));
            rd(ACS_OFS_STATUS, 32'h1 << i);
            wr(ACS_OFS_STATUS, ~(32'h1 << i));
            check("zero write", cipher_status_reg, 6'h01 << i);
            wr(ACS_OFS_STATUS, 32'h1 << i);
            check("w1c", cipher_status_reg, 6'h00);
        end
        $display("status flags done");
        // the flag loop above left every interrupt flag set
        wr(ACS_OFS_IRQ_CLR, 32'h0000_003f);
        wr(ACS_OFS_IRQ_EN, 32'h0000_0001);
        check("irq idle", irq, 1'b0);
        pulse(7'h20);
        check("irq raised", irq, 1'b1);
        rd(ACS_OFS_IRQ_STAT, 32'h0000_0001);
        rd(ACS_OFS_IRQ_CLR, 32'h0000_0000);
        wr(ACS_OFS_IRQ_CLR, 32'h0000_0001);
        check("irq cleared", irq, 1'b0);
        wr(ACS_OFS_IRQ_EN, 32'h0000_0000);
        pulse(7'h20);
        check("irq masked", irq, 1'b0);
        wr(8'h80, 32'hffff_ffff);
        rd(8'h80, 32'h0000_0000);
        $display("interrupt done");
        for (int w = 0; w < 4; w++) begin
            wr(ACS_OFS_KEY0 + 8'(4 * w), 32'h1111_1111 * (w + 1));
        end
        check("key", cipher_key, {32'h4444_4444, 32'h3333_3333,
            32'h2222_2222, 32'h1111_1111});
        rd(ACS_OFS_KEY0 + 8'h04, 32'h2222_2222);
        $display("key done");
        for (int c = 0; c < 5; c++) begin
            wr(ACS_OFS_SRC_SEL, 32'(c));
            check("source", source_port_select,
                (c < 4) ? (5'h10 >> c) : 5'h01);
        end
        $display("source select done");
        close_out();
    end
endmodule
`default_nettype wire

// file: verilog/acs_control_status.sv
// acs_control_status: software-facing start, status, key and interrupt
// logic of the cipher dma engine.
// assumes the cipher engine and the register port run on clk_sys, so
// engine events and bus strobes need no synchroniser.

`timescale 1ns/100ps
`default_nettype none

module acs_control_status #(
    parameter int KEY_WORDS = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire acs_pkg::acs_bus_req_s bus_req,
    output logic [31:0] bus_rdata,
    // cipher engine
    input wire acs_pkg::acs_engine_ev_s engine_ev,
    output logic start_req,
    output logic [127:0] cipher_key,
    output acs_pkg::acs_src_sel_s source_port_select,
    // status view and interrupt
    output logic [5:0] cipher_status_reg,
    output logic irq
);
    import acs_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (KEY_WORDS != ACS_KEY_WORDS) begin : g_key_chk
        $error("acs_control_status: only a four word key is supported");
    end

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // key word index of an address, valid only when is_key_addr holds
    function automatic logic [1:0] key_index(input logic [7:0] addr);
        logic [7:0] delta;
        delta = addr - ACS_OFS_KEY0;
        key_index = delta[3:2];
    endfunction

    function automatic logic is_key_addr(input logic [7:0] addr);
        is_key_addr = (addr >= ACS_OFS_KEY0) && (addr <= ACS_OFS_KEY3) &&
                      (addr[1:0] == 2'b00);
    endfunction

    // one-hot view of a source port code; codes above tx are unused
    function automatic acs_src_sel_s src_decode(input logic [2:0] code);
        acs_src_sel_s sel;
        sel = '0;
        unique case (code)
            ACS_SRC_SCRATCH: begin
                sel.scratch = 1'b1;
            end
            ACS_SRC_RX0: begin
                sel.rx0 = 1'b1;
            end
            ACS_SRC_RX1: begin
                sel.rx1 = 1'b1;
            end
            ACS_SRC_TX: begin
                sel.tx = 1'b1;
            end
            default: begin
                sel.unused = 1'b1;
            end
        endcase
        src_decode = sel;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    acs_state_s state_r;
    acs_state_s state_nxt;

    logic wr_start;
    logic wr_status;
    logic wr_key;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic wr_src;
    logic [5:0] status_set;
    logic [5:0] status_clr;
    logic [5:0] status_flags;
    logic [5:0] irq_set;
    logic [5:0] irq_clr;
    logic [5:0] irq_flags;
    logic [31:0] read_mux;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_start = bus_req.wr && (bus_req.addr == ACS_OFS_START);
    assign wr_status = bus_req.wr && (bus_req.addr == ACS_OFS_STATUS);
    assign wr_key = bus_req.wr && is_key_addr(bus_req.addr);
    assign wr_irq_en = bus_req.wr && (bus_req.addr == ACS_OFS_IRQ_EN);
    assign wr_irq_clr = bus_req.wr && (bus_req.addr == ACS_OFS_IRQ_CLR);
    assign wr_src = bus_req.wr && (bus_req.addr == ACS_OFS_SRC_SEL);

    // ------------------------------------------------------------------
    // status flag events
    // ------------------------------------------------------------------
    always_comb begin
        status_set = '0;
        status_set[ACS_BIT_DONE] = engine_ev.done;
        status_set[ACS_BIT_TAG_FAIL] = engine_ev.tag_fail;
        status_set[ACS_BIT_OVERFLOW] = engine_ev.overflow;
        status_set[ACS_BIT_CONFLICT] = engine_ev.conflict;
        // empty and full are levels: the flag re-arms while they hold
        status_set[ACS_BIT_EMPTY] = engine_ev.ram_empty;
        status_set[ACS_BIT_FULL] = engine_ev.ram_full;
    end

    // only ones written clear a flag; zeros leave it alone
    assign status_clr = wr_status ? bus_req.wdata[5:0] : 6'h00;

    acs_flag_bank #(
        .WIDTH(ACS_FLAG_W),
        .RESET_VAL(ACS_STATUS_RST)
    ) u_status_bank (
        .clk_sys(clk_sys),
        .reset(reset),
        .set(status_set),
        .clear(status_clr),
        .flags(status_flags)
    );

    // ------------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------------
    // ram levels raise an interrupt only on their rising edge, so that a
    // persistent empty ram does not make the interrupt uncleanable
    always_comb begin
        irq_set = status_set;
        irq_set[ACS_BIT_EMPTY] = engine_ev.ram_empty && !state_r.ram_empty_d;
        irq_set[ACS_BIT_FULL] = engine_ev.ram_full && !state_r.ram_full_d;
    end

    assign irq_clr = wr_irq_clr ? bus_req.wdata[5:0] : 6'h00;

    acs_flag_bank #(
        .WIDTH(ACS_FLAG_W),
        .RESET_VAL(ACS_IRQ_RST)
    ) u_irq_bank (
        .clk_sys(clk_sys),
        .reset(reset),
        .set(irq_set),
        .clear(irq_clr),
        .flags(irq_flags)
    );

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        read_mux = 32'h0000_0000;
        if (is_key_addr(bus_req.addr)) begin
            read_mux = state_r.key[key_index(bus_req.addr)];
        end else begin
            unique case (bus_req.addr)
                ACS_OFS_START: begin
                    read_mux[ACS_BIT_START] = state_r.start;
                end
                ACS_OFS_STATUS: begin
                    read_mux[5:0] = status_flags;
                end
                ACS_OFS_IRQ_EN: begin
                    read_mux[5:0] = state_r.irq_en;
                end
                ACS_OFS_IRQ_STAT: begin
                    read_mux[5:0] = irq_flags;
                end
                ACS_OFS_SRC_SEL: begin
                    read_mux[2:0] = state_r.src_code;
                end
                default: begin
                    // unmapped and write-only offsets read as zero
                    read_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;

        // the engine drops the request once it has begun; a new write
        // of one in that same cycle still wins and relaunches
        if (engine_ev.started) begin
            state_nxt.start = 1'b0;
        end
        if (wr_start && bus_req.wdata[ACS_BIT_START]) begin
            state_nxt.start = 1'b1;
        end

        if (wr_key) begin
            state_nxt.key[key_index(bus_req.addr)] = bus_req.wdata;
        end

        if (wr_irq_en) begin
            state_nxt.irq_en = bus_req.wdata[5:0];
        end

        if (wr_src) begin
            state_nxt.src_code = bus_req.wdata[2:0];
        end

        state_nxt.ram_empty_d = engine_ev.ram_empty;
        state_nxt.ram_full_d = engine_ev.ram_full;

        // read data stands for exactly one cycle after the strobe
        state_nxt.rdata = bus_req.rd ? read_mux : 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign bus_rdata = state_r.rdata;
    assign start_req = state_r.start;
    assign cipher_key = state_r.key;
    assign source_port_select = src_decode(state_r.src_code);
    assign cipher_status_reg = status_flags;
    assign irq = |(irq_flags & state_r.irq_en);

endmodule

`default_nettype wire

// file: verilog/acs_flag_bank.sv
// acs_flag_bank: a bank of sticky flags, set by hardware, cleared by
// writing one. assumes set and clear come from logic on clk_sys.

`timescale 1ns/100ps
`default_nettype none

module acs_flag_bank #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // flag control
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    // flag state
    output logic [WIDTH-1:0] flags
);
    import acs_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } acs_bank_s;

    acs_bank_s state_r;
    acs_bank_s state_nxt;

    if (WIDTH < 1) begin : g_width_chk
        $error("acs_flag_bank: WIDTH must be at least one");
    end

    // an event in the clearing cycle survives: set is applied last
    always_comb begin
        state_nxt = state_r;
        state_nxt.flags = (state_r.flags & ~clear) | set;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= '{flags: RESET_VAL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flags = state_r.flags;

endmodule

`default_nettype wire
